// [hdl/phy_strap_pkg.sv]
`default_nettype none
package phy_strap_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_FREQ_HZ       = 125_000_000;
  localparam int         REF_FREQ_HZ       = 25_000_000;
  localparam int         REF_DIV           = CLK_FREQ_HZ / REF_FREQ_HZ;
  localparam logic [2:0] REF_DIV_LAST      = 3'(REF_DIV - 1);
  localparam logic [2:0] REF_HIGH_CYCLES   = 3'(REF_DIV / 2);
  localparam logic [2:0] STRAP_SETTLE_LAST = 3'h3;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_INT_CTRL_STATUS  = 8'h1B;
  localparam logic [7:0] IDX_PHY_CONTROL      = 8'h1F;
  localparam logic [7:0] IDX_STRAP_READBACK   = 8'h10;
  localparam logic [7:0] IDX_MGMT_CLOCK_COUNT = 8'h11;
  localparam logic [7:0] IDX_UNMAPPED         = 8'h00;
  localparam logic [2:0] SIZE_WORD            = 3'h2;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_B2B_BIT    = 0;
  localparam int          CTRL_WAKE_BIT   = 1;
  localparam int          CTRL_POL_BIT    = 9;
  localparam int          WAKE_STATUS_BIT = 7;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [7:0]  IEN_RESET       = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rxd;
    logic       rxdv;
    logic       rxc;
    logic       rxer;
    logic       txc;
    logic       col;
    logic       crs;
  } mii_pins_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rxdv;
    logic       rxer;
    logic       col;
    logic       crs;
  } mii_core_t;

  typedef struct packed {
    logic [2:0] station_address_strap;
    logic       duplex_strap;
    logic [2:0] config_strap;
    logic       broadcast_address_disable_strap;
    logic       isolate_strap;
    logic       nand_tree_strap;
    logic       wake_event_enable_strap;
  } straps_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b10
  } phase_t;

  typedef struct packed {
    phase_t      fsm;
    logic [2:0]  cnt;
    straps_t     straps;
    logic [15:0] ctrl;
    logic [7:0]  ien;
    logic [7:0]  status;
    logic        mdc_prev;
    logic [15:0] mdc_count;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] rdata;
    mii_pins_t   pin_out;
  } state_t;

  typedef struct packed {
    logic [2:0] cnt;
  } div_state_t;

  localparam straps_t STRAPS_RESET = 11'h000;
  localparam mii_pins_t PINS_RESET = 10'h000;
  localparam logic [2:0] DIV_RESET = 3'h0;

  localparam state_t STATE_RESET = '{
    fsm:       ST_SAMPLE,
    cnt:       3'h0,
    straps:    STRAPS_RESET,
    ctrl:      CTRL_RESET,
    ien:       IEN_RESET,
    status:    STATUS_RESET,
    mdc_prev:  1'b0,
    mdc_count: 16'h0000,
    wr_pend:   1'b0,
    wr_idx:    IDX_UNMAPPED,
    rdata:     32'h0000_0000,
    pin_out:   PINS_RESET
  };

endpackage
`default_nettype wire

// [hdl/pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // ----------------------------------------------------------------
  // Two stages, only the second is read
  // ----------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.s2;
endmodule
`default_nettype wire

// [hdl/ref_divider.sv]
`timescale 1ns/1ns
`default_nettype none
module ref_divider (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick,
  output logic      ref_high
);
  import phy_strap_pkg::*;

  div_state_t st;
  div_state_t next_st;

  // ----------------------------------------------------------------
  // Divide the system clock down to the reference rate
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.cnt == REF_DIV_LAST) begin
      next_st.cnt = 3'h0;
    end else begin
      next_st.cnt = st.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.cnt <= DIV_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign tick     = (st.cnt == REF_DIV_LAST);
  assign ref_high = (st.cnt < REF_HIGH_CYCLES);
endmodule
`default_nettype wire

// [hdl/phy_strap_latch.sv]
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module phy_strap_latch (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire phy_strap_pkg::mii_pins_t mii_pin_in,
  output var phy_strap_pkg::mii_pins_t  mii_pin_out,
  output var phy_strap_pkg::mii_pins_t  mii_pin_oe,
  input  wire phy_strap_pkg::mii_core_t core_rx,
  input  wire logic                     tx_en,
  output logic                          tx_active,
  input  wire logic                     mdc,
  input  wire logic                     irq_pin_in,
  output logic                          irq_pin_out,
  output logic                          irq_pin_oe,
  input  wire logic [6:0]               event_in,
  input  wire logic                     wake_event_in,
  output logic                          irq_req,
  output var phy_strap_pkg::straps_t    straps,
  output logic                          pins_released
);
  import phy_strap_pkg::*;

  state_t    st;
  state_t    next_st;
  mii_pins_t pin_s;
  logic      irq_s;
  logic      tx_en_s;
  logic      mdc_s;
  logic      tick;
  logic      ref_high;
  logic      accept;
  logic [7:0] acc_idx;
  logic      latch;
  logic      run;
  logic      rd_clr;
  logic [7:0] ev;
  logic [7:0] clr;
  logic      wake_mode;
  logic      b2b_mode;

  // ----------------------------------------------------------------
  // Pin synchronisers and reference divider
  // ----------------------------------------------------------------
  pin_sync #(
    .W(13)
  ) u_sync (
    .clk (clk),
    .d   ({mii_pin_in, irq_pin_in, tx_en, mdc}),
    .q   ({pin_s, irq_s, tx_en_s, mdc_s})
  );

  ref_divider u_div (
    .clk      (clk),
    .rst      (rst),
    .tick     (tick),
    .ref_high (ref_high)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    accept = hsel && htrans[1] && hready && (hsize == SIZE_WORD);
    if (haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'b00) begin
      acc_idx = haddr[9:2];
    end else begin
      acc_idx = IDX_UNMAPPED;
    end
    run       = (st.fsm == ST_RUN);
    latch     = (st.fsm == ST_SAMPLE) && (st.cnt == STRAP_SETTLE_LAST);
    rd_clr    = accept && !hwrite && (acc_idx == IDX_INT_CTRL_STATUS);
    wake_mode = st.ctrl[CTRL_WAKE_BIT];
    b2b_mode  = st.ctrl[CTRL_B2B_BIT];
    clr       = rd_clr ? 8'hFF : 8'h00;
    ev        = 8'h00;
    if (run) begin
      ev = {wake_event_in && st.straps.wake_event_enable_strap, event_in};
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (st.fsm)
      ST_SAMPLE: begin
        next_st.cnt = st.cnt + 3'h1;
        if (latch) begin
          next_st.straps.station_address_strap =
            {pin_s.rxd[1], pin_s.rxd[2], pin_s.rxd[3]};
          next_st.straps.duplex_strap = pin_s.rxd[0];
          next_st.straps.config_strap =
            {pin_s.rxdv, pin_s.crs, pin_s.col};
          next_st.straps.broadcast_address_disable_strap = pin_s.rxc;
          next_st.straps.isolate_strap = pin_s.rxer;
          next_st.straps.nand_tree_strap = irq_s;
          next_st.straps.wake_event_enable_strap = pin_s.txc;
          next_st.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        next_st.cnt = st.cnt;
      end
      default: begin
        next_st.fsm = ST_SAMPLE;
      end
    endcase

    next_st.status = (st.status & ~clr) | ev;

    next_st.mdc_prev = mdc_s;
    if (mdc_s && !st.mdc_prev) begin
      next_st.mdc_count = st.mdc_count + 16'h0001;
    end

    if (tick) begin
      next_st.pin_out.rxd  = core_rx.rxd;
      next_st.pin_out.rxdv = core_rx.rxdv;
      next_st.pin_out.rxer = core_rx.rxer;
      next_st.pin_out.col  = core_rx.col;
      next_st.pin_out.crs  = core_rx.crs;
    end
    next_st.pin_out.rxc = ref_high;
    next_st.pin_out.txc = ref_high;

    next_st.wr_pend = accept && hwrite;
    next_st.wr_idx  = acc_idx;
    if (st.wr_pend) begin
      case (st.wr_idx)
        IDX_INT_CTRL_STATUS: next_st.ien  = hwdata[15:8];
        IDX_PHY_CONTROL:     next_st.ctrl = hwdata[15:0];
        default:             next_st.ien  = st.ien;
      endcase
    end

    if (accept && !hwrite) begin
      case (acc_idx)
        IDX_INT_CTRL_STATUS:  next_st.rdata = {16'h0000, st.ien, st.status};
        IDX_PHY_CONTROL:      next_st.rdata = {16'h0000, st.ctrl};
        IDX_STRAP_READBACK:   next_st.rdata = {21'h00_0000, st.straps};
        IDX_MGMT_CLOCK_COUNT: next_st.rdata = {16'h0000, st.mdc_count};
        default:              next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = st.rdata;
  assign straps        = st.straps;
  assign pins_released = run;
  assign tx_active     = tx_en_s;
  assign mii_pin_out   = st.pin_out;
  assign irq_req       = |(st.status & st.ien);

  always_comb begin
    mii_pin_oe = PINS_RESET;
    if (run && !st.straps.isolate_strap) begin
      mii_pin_oe     = ~PINS_RESET;
      mii_pin_oe.txc = !b2b_mode;
    end
  end

  always_comb begin
    irq_pin_out = 1'b0;
    irq_pin_oe  = 1'b0;
    if (run) begin
      if (wake_mode) begin
        irq_pin_oe = st.status[WAKE_STATUS_BIT];
      end else if (st.ctrl[CTRL_POL_BIT]) begin
        irq_pin_out = irq_req;
        irq_pin_oe  = 1'b1;
      end else begin
        irq_pin_oe  = irq_req;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  addr_strap_a: assert property (
    latch |=> straps.station_address_strap ==
      {$past(pin_s.rxd[1]), $past(pin_s.rxd[2]), $past(pin_s.rxd[3])})
    else $error("station address strap mismatch");

  duplex_strap_a: assert property (
    latch |=> straps.duplex_strap == $past(pin_s.rxd[0]))
    else $error("duplex strap mismatch");

  config_strap_a: assert property (
    latch |=> straps.config_strap ==
      {$past(pin_s.rxdv), $past(pin_s.crs), $past(pin_s.col)})
    else $error("config strap mismatch");

  misc_strap_a: assert property (
    latch |=> straps.broadcast_address_disable_strap == $past(pin_s.rxc)
      && straps.isolate_strap == $past(pin_s.rxer)
      && straps.nand_tree_strap == $past(irq_s)
      && straps.wake_event_enable_strap == $past(pin_s.txc))
    else $error("option strap mismatch");

  strap_hold_a: assert property (
    run ##1 run |-> $stable(straps))
    else $error("straps changed after latching");

  release_a: assert property (
    !run |-> mii_pin_oe == PINS_RESET && !irq_pin_oe)
    else $error("pins driven before straps latched");

  drive_pins_a: assert property (
    run && !straps.isolate_strap |-> mii_pin_oe.rxd == 4'hF && mii_pin_oe.rxdv
      && mii_pin_oe.rxc && mii_pin_oe.rxer && (mii_pin_oe.txc == !b2b_mode))
    else $error("receive pins not driven");

  txc_b2b_a: assert property (
    b2b_mode |-> !mii_pin_oe.txc)
    else $error("transmit clock driven in back-to-back mode");

  read_clear_a: assert property (
    rd_clr |=> st.status == $past(ev))
    else $error("status not cleared by read");

  irq_low_a: assert property (
    run && !wake_mode && !st.ctrl[CTRL_POL_BIT] |->
      irq_pin_oe == irq_req && !irq_pin_out)
    else $error("active low interrupt pin wrong");

  irq_high_a: assert property (
    run && !wake_mode && st.ctrl[CTRL_POL_BIT] |-> irq_pin_oe && irq_pin_out == irq_req)
    else $error("active high interrupt pin wrong");

  wake_pin_a: assert property (
    run && wake_mode && st.status[WAKE_STATUS_BIT] |-> irq_pin_oe && !irq_pin_out)
    else $error("wake pin not driven low");

  ref_tick_a: assert property (
    tick |=> !tick [*4] ##1 tick)
    else $error("reference tick period wrong");

  bus_okay_a: assert property (
    hreadyout && !hresp)
    else $error("bus response not ready and okay");

  rdata_hold_a: assert property (
    !(accept && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  unmapped_read_a: assert property (
    accept && !hwrite && acc_idx == IDX_UNMAPPED |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  strap_read_a: assert property (
    accept && !hwrite && acc_idx == IDX_STRAP_READBACK |=>
      hrdata == {21'h00_0000, $past(straps)})
    else $error("strap readback wrong");

  run_entry_a: assert property (
    $rose(run) |-> $past(latch))
    else $error("pins released without strap latch");

  isolate_oe_a: assert property (
    run && st.straps.isolate_strap |-> mii_pin_oe == PINS_RESET)
    else $error("pins driven while isolated");

  wake_only_a: assert property (
    !st.straps.wake_event_enable_strap |-> !st.status[WAKE_STATUS_BIT])
    else $error("wake status set while wake disabled");

  idle_status_a: assert property (
    !run |-> st.status == STATUS_RESET)
    else $error("status set before straps latched");

  status_set_a: assert property (
    ev != 8'h00 |=> (st.status & $past(ev)) == $past(ev))
    else $error("event lost");

  status_hold_a: assert property (
    !rd_clr && ev == 8'h00 |=> $stable(st.status))
    else $error("status changed without event or read");

  ien_write_a: assert property (
    st.wr_pend && st.wr_idx == IDX_INT_CTRL_STATUS |=> st.ien == $past(hwdata[15:8]))
    else $error("interrupt enable write lost");

  ien_hold_a: assert property (
    !(st.wr_pend && st.wr_idx == IDX_INT_CTRL_STATUS) |=> $stable(st.ien))
    else $error("interrupt enable changed without write");

  ctrl_write_a: assert property (
    st.wr_pend && st.wr_idx == IDX_PHY_CONTROL |=> st.ctrl == $past(hwdata[15:0]))
    else $error("control write lost");

  ctrl_hold_a: assert property (
    !(st.wr_pend && st.wr_idx == IDX_PHY_CONTROL) |=> $stable(st.ctrl))
    else $error("control changed without write");

  mdc_count_a: assert property (
    mdc_s && !st.mdc_prev |=> st.mdc_count == $past(st.mdc_count) + 16'h0001)
    else $error("management clock edge not counted");

  mdc_hold_a: assert property (
    !(mdc_s && !st.mdc_prev) |=> $stable(st.mdc_count))
    else $error("management clock count changed without edge");

  rx_copy_a: assert property (
    tick |=> mii_pin_out.rxd == $past(core_rx.rxd) && mii_pin_out.rxdv == $past(core_rx.rxdv)
      && mii_pin_out.rxer == $past(core_rx.rxer) && mii_pin_out.col == $past(core_rx.col)
      && mii_pin_out.crs == $past(core_rx.crs))
    else $error("receive pins not loaded on tick");

  rx_hold_a: assert property (
    !tick |=> $stable(mii_pin_out.rxd) && $stable(mii_pin_out.rxdv))
    else $error("receive pins changed between ticks");

  ref_clock_a: assert property (
    tick |-> ##2 (mii_pin_out.rxc && mii_pin_out.txc)
      ##2 !(mii_pin_out.rxc || mii_pin_out.txc))
    else $error("receive clock shape wrong");

  run_c: cover property (latch ##1 run);
  irq_c: cover property (run && irq_req && !irq_pin_out && irq_pin_oe);
  wake_c: cover property (run && wake_mode && irq_pin_oe);
  rdclr_c: cover property (rd_clr && st.status != 8'h00);
  strap_read_c: cover property (accept && !hwrite && acc_idx == IDX_STRAP_READBACK);

endmodule
`default_nettype wire

// [sim/mac_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mac_model #(
  parameter int PULSES = 5
) (
  input  wire logic start,
  input  wire logic tx_frame,
  output logic      mdc,
  output logic      tx_en,
  output logic      busy
);
  // ----------------------------------------------------------------
  // Transmit framing and management clock
  // ----------------------------------------------------------------
  assign tx_en = tx_frame;

  initial begin
    mdc  = 1'b0;
    busy = 1'b0;
  end

  // Clock stands low outside a management frame, 125 ns period inside
  always @(posedge start) begin
    busy = 1'b1;
    repeat (PULSES) begin
      #62 mdc = 1'b1;
      #63 mdc = 1'b0;
    end
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import phy_strap_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = SIZE_WORD;
  logic        hreadyout, hresp, tx_en, tx_active, mdc, tx_frame = 1'b0, start = 1'b0;
  logic        irq_pull = 1'b1, irq_pin_in, irq_pin_out, irq_pin_oe, irq_req, busy;
  logic        wake_event_in = 1'b0, pins_released, prev_rxc;
  logic [6:0]  event_in = 7'h00;
  mii_pins_t   pull = 10'h000, mii_pin_in, mii_pin_out, mii_pin_oe;
  mii_core_t   core_rx = 8'h00;
  straps_t     straps, exp_s;
  int          n_errors = 0, check_count = 0, edges;

  always #4 clk = ~clk;
  assign hready     = hreadyout;
  assign mii_pin_in = (mii_pin_oe & mii_pin_out) | (~mii_pin_oe & pull);
  assign irq_pin_in = irq_pin_oe ? irq_pin_out : irq_pull;

  phy_strap_latch DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mii_pin_in(mii_pin_in), .mii_pin_out(mii_pin_out),
    .mii_pin_oe(mii_pin_oe), .core_rx(core_rx), .tx_en(tx_en), .tx_active(tx_active),
    .mdc(mdc), .irq_pin_in(irq_pin_in), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
    .event_in(event_in), .wake_event_in(wake_event_in), .irq_req(irq_req), .straps(straps),
    .pins_released(pins_released));

  mac_model #(.PULSES(5)) partner (.start(start), .tx_frame(tx_frame), .mdc(mdc),
    .tx_en(tx_en), .busy(busy));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hready !== 1'b1 && i < 100);
    if (hready !== 1'b1) begin
      n_errors++;
      results;
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic pulse(input logic [6:0] e, input logic w);
    @(posedge clk);
    event_in      <= e;
    wake_event_in <= w;
    @(posedge clk);
    event_in      <= 7'h00;
    wake_event_in <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic do_reset(input mii_pins_t p, input logic irq);
    int i;
    @(posedge clk);
    pull     <= p;
    irq_pull <= irq;
    rst      <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({22'h0, mii_pin_oe}, 32'h0000_0000);
    i = 0;
    while (pins_released !== 1'b1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    if (pins_released !== 1'b1) begin
      n_errors++;
      results;
    end
    exp_s = {p.rxd[1], p.rxd[2], p.rxd[3], p.rxd[0], p.rxdv, p.crs, p.col, p.rxc, p.rxer,
             irq, p.txc};
    @(posedge clk);
    chk({21'h0, straps}, {21'h0, exp_s});
    rd_chk(32'h0000_0040, {21'h0, exp_s});
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #400000;
    n_errors++;
    results;
  end

  initial begin
    do_reset(10'h2A9, 1'b0);
    chk({22'h0, mii_pin_oe}, 32'h0000_0000);
    pull <= 10'h156;
    repeat (10) @(posedge clk);
    chk({21'h0, straps}, {21'h0, exp_s});
    $display("test straps_a done");
    do_reset(10'h156, 1'b1);
    chk({22'h0, mii_pin_oe}, 32'h0000_03FF);
    rd_chk(32'h0000_0000, 32'h0000_0000);
    core_rx <= 8'hA5;
    repeat (12) @(posedge clk);
    chk({24'h0, mii_pin_out.rxd, mii_pin_out.rxdv, mii_pin_out.rxer, mii_pin_out.col,
         mii_pin_out.crs}, 32'h0000_00A5);
    edges = 0;
    prev_rxc = mii_pin_out.rxc;
    repeat (50) begin
      @(posedge clk);
      if (mii_pin_out.rxc === 1'b1 && prev_rxc === 1'b0) edges++;
      prev_rxc = mii_pin_out.rxc;
    end
    chk(edges, 32'h0000_000A);
    ahb(1'b1, 32'h0000_007C, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({22'h0, mii_pin_oe}, 32'h0000_03FB);
    ahb(1'b1, 32'h0000_007C, 32'h0000_0000);
    $display("test pins done");
    ahb(1'b1, 32'h0000_006C, 32'h0000_0100);
    pulse(7'h02, 1'b0);
    chk({30'h0, irq_req, irq_pin_oe}, 32'h0000_0000);
    pulse(7'h01, 1'b0);
    chk({29'h0, irq_req, irq_pin_oe, irq_pin_out}, 32'h0000_0006);
    ahb(1'b1, 32'h0000_007C, 32'h0000_0200);
    repeat (2) @(posedge clk);
    chk({30'h0, irq_pin_oe, irq_pin_out}, 32'h0000_0003);
    rd_chk(32'h0000_006C, 32'h0000_0103);
    rd_chk(32'h0000_006C, 32'h0000_0100);
    chk({31'h0, irq_req}, 32'h0000_0000);
    ahb(1'b1, 32'h0000_007C, 32'h0000_0002);
    pulse(7'h00, 1'b1);
    chk({30'h0, irq_pin_oe, irq_pin_out}, 32'h0000_0002);
    rd_chk(32'h0000_006C, 32'h0000_0180);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_pin_oe}, 32'h0000_0000);
    $display("test irq done");
    tx_frame <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, tx_active}, 32'h0000_0001);
    tx_frame <= 1'b0;
    start    <= 1'b1;
    repeat (200) @(posedge clk);
    start <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, busy}, 32'h0000_0000);
    rd_chk(32'h0000_0044, 32'h0000_0005);
    $display("test link done");
    results;
  end
endmodule
`default_nettype wire
